// ---- apic_config.sv ----
// Summary of operation
// - A zero enable bit holds its analog sub-circuit powered down.
// - Bit 31 lets conversion-complete raise the interrupt.
// - Bit 30 lets the mid-conversion trigger flag raise the interrupt.
// - Bit 29 lets modulator overload raise the interrupt.
// - Bit 28 lets the quartic filter range flag raise the interrupt.
// - Bit 27 lets the cubic filter range flag raise the interrupt.
// - Bit 24 gates the combined interrupt; zero keeps it low.
// - Bits 15:14 set start delay after modulator reset; 00 is one clock.
// - Bit 13 set: one sweep then wait; clear: sweeps restart continuously.
// - Bit 10 enables the phase generator, else powers it down.
// - Bit 9 enables the bias generator; clear powers it down here.
// - Bit 7 enables the reference current, else powers it down.
// - Bit 5 enables the positive reference buffer, else powers it down.
// - Setting bit 4 enables second filter clock; writing zero does nothing.
// - Bit 3 enables the anti-alias filter, else powers it down.
// - Bit 2 powers only the modulator, never the filter clocks.
// - Bit 1 enables the gain amplifier, else powers it down.
// - Bit 0 zero powers down every converter block regardless of others.
// - Bit 0 zero stops both filter clocks and resets the analog macro.
// - Bit 0 zero gates off the converter clock.
// - Interrupt enables never alter stored status flags.
// - Command bit 7 cancels continuous mode after the current sweep.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module apic_config (
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic conversion_done_flag,
    input wire logic mid_conversion_trigger_flag,
    input wire logic modulator_overload_flag,
    input wire logic quartic_range_flag,
    input wire logic cubic_range_flag,
    input wire logic sweep_done,
    output logic phase_generator_pd,
    output logic bias_generator_pd,
    output logic reference_current_pd,
    output logic positive_buffer_pd,
    output logic antialias_pd,
    output logic modulator_pd,
    output logic gain_amp_pd,
    output logic cubic_filter_clk_en,
    output logic quartic_filter_clk_en,
    output logic converter_clk_en,
    output logic analog_macro_rst,
    output logic [1:0] post_reset_start_delay,
    output logic one_pass_select,
    output logic sweep_start,
    output logic sweep_active,
    output logic combined_converter_irq
);

    // ****************************************
    // Bus slave
    // ****************************************
    logic aw_got_r;
    logic w_got_r;
    logic [3:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic do_write;
    logic [31:0] strobed;
    logic [31:0] cfg_r;
    logic [31:0] cfg_nxt;
    logic trigger_cmd;
    logic cancel_cmd;
    logic cancel_pend_r;
    logic [4:0] flags;
    logic [4:0] flag_en;
    apic_pkg::apic_sweep_t state_r;

    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready = !w_got_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign do_write = aw_got_r && w_got_r && !bvalid_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_got_r <= 1'b0;
            waddr_r <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            waddr_r <= s_axi_awaddr[3:0];
        end else if (do_write) begin
            aw_got_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            w_got_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (do_write) begin
            w_got_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_r <= 1'b0;
            bresp_r <= apic_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            if (waddr_r == apic_pkg::CFG_OFFSET || waddr_r == apic_pkg::CMD_OFFSET) begin
                bresp_r <= apic_pkg::RESP_OKAY;
            end else begin
                bresp_r <= apic_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= apic_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rresp_r <= apic_pkg::RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            unique case (s_axi_araddr[3:0])
                apic_pkg::CFG_OFFSET: begin
                    rdata_r <= cfg_r;
                end
                apic_pkg::CMD_OFFSET: begin
                    rdata_r <= 32'h0000_0000;
                end
                apic_pkg::STAT_OFFSET: begin
                    // Raw flags are shown unmasked by the interrupt enables.
                    rdata_r[apic_pkg::STAT_RUN_BIT] <= (state_r == apic_pkg::SWEEP_RUN);
                    rdata_r[apic_pkg::STAT_CANCEL_BIT] <= cancel_pend_r;
                    rdata_r[apic_pkg::STAT_FLAG_LSB +: 5] <= flags;
                end
                default: begin
                    rresp_r <= apic_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ****************************************
    // Configuration register
    // ****************************************
    for (genvar i = 0; i < 4; i++) begin : g_strobe
        assign strobed[8*i +: 8] = wstrb_r[i] ? wdata_r[8*i +: 8] : cfg_r[8*i +: 8];
    end

    always_comb begin
        cfg_nxt = cfg_r;
        if (do_write && waddr_r == apic_pkg::CFG_OFFSET) begin
            cfg_nxt = strobed & apic_pkg::CFG_RW_MASK;
            cfg_nxt[apic_pkg::SECOND_CLK_BIT] = cfg_r[apic_pkg::SECOND_CLK_BIT]
                | strobed[apic_pkg::SECOND_CLK_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_r <= apic_pkg::CFG_RESET;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    assign trigger_cmd = do_write && waddr_r == apic_pkg::CMD_OFFSET
        && wstrb_r[0] && wdata_r[apic_pkg::TRIGGER_BIT];
    assign cancel_cmd = do_write && waddr_r == apic_pkg::CMD_OFFSET
        && wstrb_r[0] && wdata_r[apic_pkg::CANCEL_BIT];

    // ****************************************
    // Analog power and clock controls
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_generator_pd <= 1'b1;
            bias_generator_pd <= 1'b1;
            reference_current_pd <= 1'b1;
            positive_buffer_pd <= 1'b1;
            antialias_pd <= 1'b1;
            modulator_pd <= 1'b1;
            gain_amp_pd <= 1'b1;
        end else begin
            phase_generator_pd <= !(cfg_r[0] && cfg_r[apic_pkg::PHASE_GEN_BIT]);
            bias_generator_pd <= !(cfg_r[0] && cfg_r[apic_pkg::BIAS_GEN_BIT]);
            reference_current_pd <= !(cfg_r[0] && cfg_r[apic_pkg::REF_CUR_BIT]);
            positive_buffer_pd <= !(cfg_r[0] && cfg_r[apic_pkg::POS_BUF_BIT]);
            antialias_pd <= !(cfg_r[0] && cfg_r[apic_pkg::ANTIALIAS_BIT]);
            modulator_pd <= !(cfg_r[0] && cfg_r[apic_pkg::MODULATOR_BIT]);
            gain_amp_pd <= !(cfg_r[0] && cfg_r[apic_pkg::GAIN_AMP_BIT]);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cubic_filter_clk_en <= 1'b0;
            quartic_filter_clk_en <= 1'b0;
            converter_clk_en <= 1'b0;
            analog_macro_rst <= 1'b1;
            post_reset_start_delay <= 2'h0;
            one_pass_select <= 1'b0;
        end else begin
            cubic_filter_clk_en <= cfg_r[apic_pkg::CONV_EN_BIT];
            quartic_filter_clk_en <= cfg_r[apic_pkg::CONV_EN_BIT]
                && cfg_r[apic_pkg::SECOND_CLK_BIT];
            analog_macro_rst <= !cfg_r[apic_pkg::CONV_EN_BIT];
            converter_clk_en <= cfg_r[apic_pkg::CONV_EN_BIT];
            post_reset_start_delay <= cfg_r[apic_pkg::DELAY_LSB +: 2];
            one_pass_select <= cfg_r[apic_pkg::ONE_PASS_BIT];
        end
    end

    // ****************************************
    // Sweep control
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            cancel_pend_r <= 1'b0;
        end else if (cancel_cmd) begin
            cancel_pend_r <= 1'b1;
        end else if (state_r == apic_pkg::SWEEP_IDLE) begin
            cancel_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= apic_pkg::SWEEP_IDLE;
            sweep_start <= 1'b0;
        end else begin
            sweep_start <= 1'b0;
            unique case (state_r)
                apic_pkg::SWEEP_IDLE: begin
                    if (trigger_cmd && cfg_r[apic_pkg::CONV_EN_BIT]) begin
                        state_r <= apic_pkg::SWEEP_RUN;
                        sweep_start <= 1'b1;
                    end
                end
                apic_pkg::SWEEP_RUN: begin
                    if (!cfg_r[apic_pkg::CONV_EN_BIT]) begin
                        state_r <= apic_pkg::SWEEP_IDLE;
                    end else if (sweep_done) begin
                        if (cfg_r[apic_pkg::ONE_PASS_BIT] || cancel_pend_r || cancel_cmd) begin
                            state_r <= apic_pkg::SWEEP_IDLE;
                        end else begin
                            sweep_start <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    assign sweep_active = (state_r == apic_pkg::SWEEP_RUN);

    // ****************************************
    // Interrupt combine
    // ****************************************
    // flags used unaltered
    assign flags = {conversion_done_flag, mid_conversion_trigger_flag,
        modulator_overload_flag, quartic_range_flag, cubic_range_flag};
    assign flag_en = cfg_r[apic_pkg::CUBIC_IEN_BIT +: 5];

    always_ff @(posedge clk) begin
        if (rst) begin
            combined_converter_irq <= 1'b0;
        end else begin
            combined_converter_irq <= cfg_r[apic_pkg::MASTER_IRQ_BIT] && |(flags & flag_en);
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_last_sweep;
        (state_r == apic_pkg::SWEEP_RUN) && sweep_done && cfg_r[0];
    endsequence

    sequence s_go_idle;
        (state_r == apic_pkg::SWEEP_IDLE) && !sweep_start;
    endsequence

    all_pd_a: assert property (
        !cfg_r[0] |=> modulator_pd && gain_amp_pd && antialias_pd && bias_generator_pd
        && phase_generator_pd && reference_current_pd && positive_buffer_pd)
        else $error("converter disable did not power down all blocks");
    amp_pd_a: assert property (cfg_r[0] && cfg_r[1] |=> !gain_amp_pd)
        else $error("gain amplifier not enabled");
    filter_stop_a: assert property (
        !cfg_r[0] |=> analog_macro_rst && !cubic_filter_clk_en && !quartic_filter_clk_en)
        else $error("filter clocks or macro reset wrong while disabled");
    mod_only_a: assert property (
        cfg_r[0] && !cfg_r[2] |=> cubic_filter_clk_en && !analog_macro_rst)
        else $error("modulator power-down stopped the filter clock");
    conv_clk_a: assert property (converter_clk_en == $past(cfg_r[0]))
        else $error("converter clock gate does not follow enable");
    irq_gate_a: assert property (!cfg_r[24] |=> !combined_converter_irq)
        else $error("interrupt raised with master gate off");
    irq_done_a: assert property (
        cfg_r[24] && cfg_r[31] && conversion_done_flag |=> combined_converter_irq)
        else $error("enabled completion did not raise interrupt");
    irq_mask_a: assert property (
        (flags & flag_en) == 5'h00 |=> !combined_converter_irq)
        else $error("interrupt raised with no enabled flag");
    one_pass_a: assert property (s_last_sweep ##0 cfg_r[13] |=> s_go_idle)
        else $error("single sweep did not stop");
    restart_a: assert property (
        s_last_sweep ##0 !cfg_r[13] && !cancel_pend_r && !cancel_cmd
        |=> sweep_start && sweep_active)
        else $error("continuous sweep did not restart");
    cancel_hold_a: assert property (
        sweep_active && cancel_pend_r && !sweep_done && cfg_r[0] |=> sweep_active)
        else $error("cancel cut a sweep short");
    cancel_end_a: assert property (s_last_sweep ##0 cancel_pend_r |=> s_go_idle)
        else $error("cancelled sweep did not halt");
    second_clk_a: assert property (cfg_r[4] |=> cfg_r[4])
        else $error("second filter clock bit was cleared");
    reserved_a: assert property ((cfg_r & ~apic_pkg::CFG_RW_MASK) == 32'h0000_0000)
        else $error("reserved configuration bit set");

endmodule : apic_config

`default_nettype wire

// ---- apic_pkg.sv ----
package apic_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] CFG_OFFSET = 4'h0;
    localparam logic [3:0] CMD_OFFSET = 4'h4;
    localparam logic [3:0] STAT_OFFSET = 4'h8;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_RW_MASK = 32'hf900_e6bf;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // Configuration fields
    // ****************************************
    localparam int DONE_IEN_BIT = 31;
    localparam int RETRIG_IEN_BIT = 30;
    localparam int OVL_IEN_BIT = 29;
    localparam int QUARTIC_IEN_BIT = 28;
    localparam int CUBIC_IEN_BIT = 27;
    localparam int MASTER_IRQ_BIT = 24;
    localparam int DELAY_LSB = 14;
    localparam int ONE_PASS_BIT = 13;
    localparam int PHASE_GEN_BIT = 10;
    localparam int BIAS_GEN_BIT = 9;
    localparam int REF_CUR_BIT = 7;
    localparam int POS_BUF_BIT = 5;
    localparam int SECOND_CLK_BIT = 4;
    localparam int ANTIALIAS_BIT = 3;
    localparam int MODULATOR_BIT = 2;
    localparam int GAIN_AMP_BIT = 1;
    localparam int CONV_EN_BIT = 0;

    // ****************************************
    // Command and status fields
    // ****************************************
    localparam int TRIGGER_BIT = 0;
    localparam int CANCEL_BIT = 7;
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_CANCEL_BIT = 1;
    localparam int STAT_FLAG_LSB = 2;

    typedef enum logic [0:0] {SWEEP_IDLE, SWEEP_RUN} apic_sweep_t;

endpackage : apic_pkg

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sweep_done = 1'b0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [4:0] flags = 5'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, post_reset_start_delay;
    logic [31:0] s_axi_rdata, cfg_m, rd_data;
    logic phase_generator_pd, bias_generator_pd, reference_current_pd, positive_buffer_pd;
    logic antialias_pd, modulator_pd, gain_amp_pd, cubic_filter_clk_en, quartic_filter_clk_en;
    logic converter_clk_en, analog_macro_rst, one_pass_select, sweep_start, sweep_active;
    logic combined_converter_irq;
    logic [1:0] resp;
    logic [13:0] ctl;
    int bad_count = 0;
    int samples_checked = 0;
    int starts_seen = 0;
    int s0;

    always #5 clk = ~clk;

    apic_config u_dut (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .conversion_done_flag(flags[4]), .mid_conversion_trigger_flag(flags[3]),
        .modulator_overload_flag(flags[2]), .quartic_range_flag(flags[1]),
        .cubic_range_flag(flags[0]), .sweep_done(sweep_done),
        .phase_generator_pd(phase_generator_pd), .bias_generator_pd(bias_generator_pd),
        .reference_current_pd(reference_current_pd), .positive_buffer_pd(positive_buffer_pd),
        .antialias_pd(antialias_pd), .modulator_pd(modulator_pd), .gain_amp_pd(gain_amp_pd),
        .cubic_filter_clk_en(cubic_filter_clk_en), .quartic_filter_clk_en(quartic_filter_clk_en),
        .converter_clk_en(converter_clk_en), .analog_macro_rst(analog_macro_rst),
        .post_reset_start_delay(post_reset_start_delay), .one_pass_select(one_pass_select),
        .sweep_start(sweep_start), .sweep_active(sweep_active),
        .combined_converter_irq(combined_converter_irq));

    assign ctl = {phase_generator_pd, bias_generator_pd, reference_current_pd,
        positive_buffer_pd, antialias_pd, modulator_pd, gain_amp_pd, cubic_filter_clk_en,
        quartic_filter_clk_en, converter_clk_en, analog_macro_rst, post_reset_start_delay,
        one_pass_select};

    always @(posedge clk) begin
        if (sweep_start === 1'b1) starts_seen <= starts_seen + 1;
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [13:0] exp_ctl(input logic [31:0] c);
        logic on;
        on = c[0];
        return {!(on && c[10]), !(on && c[9]), !(on && c[7]), !(on && c[5]), !(on && c[3]),
            !(on && c[2]), !(on && c[1]), on, on && c[4], on, !on, c[15:14], c[13]};
    endfunction : exp_ctl

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h3;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (n < 50) begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                n = 100;
            end
        end
        if (n != 100) check(32'h1, 32'h0);
    endtask : axi_wr

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h3;
        d = 32'h0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (n < 50) begin
            @(posedge clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                n = 100;
            end
        end
        if (n != 100) check(32'h2, 32'h0);
    endtask : axi_rd

    task automatic cfg_write(input logic [31:0] d);
        axi_wr(32'(apic_pkg::CFG_OFFSET), d, resp);
        check(32'(resp), 32'(apic_pkg::RESP_OKAY));
        cfg_m = (d & apic_pkg::CFG_RW_MASK) | (cfg_m & 32'h0000_0010);
    endtask : cfg_write

    task automatic pulse_done();
        @(posedge clk);
        sweep_done <= 1'b1;
        @(posedge clk);
        sweep_done <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse_done

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        wrap_up();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        logic [31:0] corners [5];
        corners = '{32'hffff_ffff, 32'h0000_0000, 32'h0000_0001, 32'h0000_04be, 32'h0100_c000};
        void'($urandom(32'ha92e));
        cfg_m = apic_pkg::CFG_RESET;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        axi_rd(32'(apic_pkg::CFG_OFFSET), rd_data, resp);
        check(rd_data, 32'h0);
        check(32'(ctl), 32'(exp_ctl(32'h0)));
        $display("Test reset state done");
        for (int i = 0; i < 30; i++) begin
            cfg_write(i < 5 ? corners[i] : $urandom);
            axi_rd(32'(apic_pkg::CFG_OFFSET), rd_data, resp);
            check(rd_data, cfg_m);
            repeat (2) @(posedge clk);
            check(32'(ctl), 32'(exp_ctl(cfg_m)));
            flags <= 5'($urandom);
            repeat (3) @(posedge clk);
            check(32'(combined_converter_irq),
                32'(cfg_m[24] && |(flags & cfg_m[31:27])));
            axi_rd(32'(apic_pkg::STAT_OFFSET), rd_data, resp);
            check(32'(rd_data[6:2]), 32'(flags));
            check(32'(resp), 32'(apic_pkg::RESP_OKAY));
        end
        $display("Test configuration and interrupt done");
        s_axi_wstrb <= 4'h1;
        axi_wr(32'(apic_pkg::CFG_OFFSET), 32'hffff_ffaa, resp);
        s_axi_wstrb <= 4'hf;
        check(32'(resp), 32'(apic_pkg::RESP_OKAY));
        cfg_m = (cfg_m & 32'hffff_ff10) | (32'h0000_00aa & apic_pkg::CFG_RW_MASK);
        axi_rd(32'(apic_pkg::CFG_OFFSET), rd_data, resp);
        check(rd_data, cfg_m);
        $display("Test byte strobes done");
        axi_wr(32'h0000_000c, 32'hffff_ffff, resp);
        check(32'(resp), 32'(apic_pkg::RESP_SLVERR));
        axi_wr(32'(apic_pkg::STAT_OFFSET), 32'hffff_ffff, resp);
        check(32'(resp), 32'(apic_pkg::RESP_SLVERR));
        axi_rd(32'h0000_000c, rd_data, resp);
        check(32'(resp), 32'(apic_pkg::RESP_SLVERR));
        axi_rd(32'(apic_pkg::CFG_OFFSET), rd_data, resp);
        check(rd_data, cfg_m);
        $display("Test refused accesses done");
        flags <= 5'h0;
        cfg_write(32'h0000_2001);
        s0 = starts_seen;
        axi_wr(32'(apic_pkg::CMD_OFFSET), 32'h0, resp);
        repeat (2) @(posedge clk);
        check(32'(sweep_active), 32'h0);
        axi_wr(32'(apic_pkg::CMD_OFFSET), 32'h1, resp);
        check(32'(resp), 32'(apic_pkg::RESP_OKAY));
        repeat (2) @(posedge clk);
        check(32'(sweep_active), 32'h1);
        check(32'(starts_seen - s0), 32'h1);
        pulse_done();
        check(32'(sweep_active), 32'h0);
        check(32'(starts_seen - s0), 32'h1);
        cfg_write(32'h0000_0001);
        axi_wr(32'(apic_pkg::CMD_OFFSET), 32'h1, resp);
        pulse_done();
        check(32'(sweep_active), 32'h1);
        check(32'(starts_seen - s0), 32'h3);
        axi_wr(32'(apic_pkg::CMD_OFFSET), 32'h80, resp);
        repeat (2) @(posedge clk);
        check(32'(sweep_active), 32'h1);
        pulse_done();
        check(32'(sweep_active), 32'h0);
        check(32'(starts_seen - s0), 32'h3);
        $display("Test sweep control done");
        wrap_up();
    end

endmodule : testbench

`default_nettype wire
